// ==== verilog/vpm_regs.sv ====
/*
 * virtual-to-physical partition map registers with access checks
 * and the labelling lookup. assumes all inputs come from logic on clk.
 */
`timescale 1ns/10ps
`default_nettype none

module vpm_regs #(
	parameter int NUM_REGS = vpm_pkg::DEF_NUM_REGS
) (
	// clock and reset
	input wire logic clk,
	input wire logic rstn,
	// system register request
	input wire logic req_valid,
	input wire logic req_write,
	input wire logic [1:0] req_op0,
	input wire logic [2:0] req_op1,
	input wire logic [3:0] req_crn,
	input wire logic [3:0] req_crm,
	input wire logic [2:0] req_op2,
	input wire logic [63:0] req_wdata,
	// processor context
	input wire logic [1:0] cur_el,
	input wire logic el2_enabled,
	input wire logic nested_virt_bit,
	input wire logic nested_virt_memory_bit,
	input wire logic el3_present,
	input wire logic trap_lower_levels,
	input wire logic halted,
	input wire logic secure_debug_disable,
	input wire logic virtualization_present,
	// answer
	output logic resp_valid,
	output vpm_pkg::vpm_kind_e resp_kind,
	output logic [5:0] resp_class,
	output logic [11:0] resp_nv_addr,
	output logic [63:0] resp_rdata,
	output logic [2:0] map_register_max_index,
	// labelling path
	input wire logic el0_map_enable,
	input wire logic el1_map_enable,
	input wire logic [31:0] map_entry_valid,
	input wire logic src_is_el1,
	input wire logic [15:0] src_partition_i,
	input wire logic [15:0] src_partition_d,
	output logic [15:0] label_partition_i,
	output logic [15:0] label_partition_d,
	output logic label_miss_i,
	output logic label_miss_d
);

	// ************************************
	// state
	// ************************************
	localparam logic [15:0] NUM_IDS =
		16'(vpm_pkg::ENTRIES_PER_REG * NUM_REGS);

	typedef struct packed {
		logic [NUM_REGS-1:0][63:0] map;
		logic resp_valid;
		vpm_pkg::vpm_kind_e kind;
		logic [5:0] cls;
		logic [11:0] nv_addr;
		logic [63:0] rdata;
		logic [15:0] lab_i;
		logic [15:0] lab_d;
		logic miss_i;
		logic miss_d;
	} vpm_state_s;

	vpm_state_s r;
	vpm_state_s next_r;

	// ************************************
	// decode
	// ************************************
	logic sel;
	logic present;
	logic map_apply;

	assign sel = req_valid && req_op0 == vpm_pkg::ENC_OP0 &&
		req_op1 == vpm_pkg::ENC_OP1 &&
		req_crn == vpm_pkg::ENC_CRN &&
		req_crm == vpm_pkg::ENC_CRM;
	assign present = virtualization_present &&
		32'(req_op2) < NUM_REGS;
	// RAZ when virtualization is absent
	assign map_register_max_index = virtualization_present ?
		3'(NUM_REGS - 1) : 3'h0;

	// trap-lower check shared by el1 and el2
	function automatic vpm_pkg::vpm_kind_e el3_trap();
		if (halted && secure_debug_disable) begin
			return vpm_pkg::KIND_UNDEF;
		end
		return vpm_pkg::KIND_TRAP_EL3;
	endfunction : el3_trap

	function automatic vpm_pkg::vpm_kind_e decide();
		logic tl;
		tl = el3_present && trap_lower_levels;
		if (!present) begin
			return vpm_pkg::KIND_UNDEF;
		end
		unique case (cur_el)
			vpm_pkg::EL0: begin
				return vpm_pkg::KIND_UNDEF;
			end
			vpm_pkg::EL1: begin
				if (el2_enabled && nested_virt_bit &&
					nested_virt_memory_bit) begin
					return vpm_pkg::KIND_NESTED_SAVE_AREA;
				end
				if (el2_enabled && nested_virt_bit) begin
					if (tl) begin
						return el3_trap();
					end
					return vpm_pkg::KIND_TRAP_EL2;
				end
				return vpm_pkg::KIND_UNDEF;
			end
			vpm_pkg::EL2: begin
				if (tl) begin
					return el3_trap();
				end
				return vpm_pkg::KIND_OK;
			end
			vpm_pkg::EL3: begin
				return vpm_pkg::KIND_OK;
			end
		endcase
		return vpm_pkg::KIND_UNDEF;
	endfunction : decide

	// entry n sits in register n/4, lane n%4, low lane at bit 0
	function automatic logic [15:0] lookup(
		input logic [NUM_REGS-1:0][63:0] m,
		input logic [15:0] vid
	);
		logic [63:0] w;
		w = m[vid[4:2]];
		return w[vid[1:0]*vpm_pkg::ENTRY_W +: vpm_pkg::ENTRY_W];
	endfunction : lookup

	// ************************************
	// labelling
	// ************************************
	// no effect at all unless el2 is enabled
	assign map_apply = virtualization_present && el2_enabled &&
		(src_is_el1 ? el1_map_enable : el0_map_enable);

	function automatic logic entry_ok(input logic [15:0] vid);
		return vid < NUM_IDS && map_entry_valid[vid[4:0]];
	endfunction : entry_ok

	// ************************************
	// next state
	// ************************************
	always_comb begin
		vpm_pkg::vpm_kind_e k;
		k = decide();
		next_r = r;
		next_r.resp_valid = 1'b0;
		if (sel) begin
			next_r.resp_valid = 1'b1;
			next_r.kind = k;
			next_r.cls = (k == vpm_pkg::KIND_TRAP_EL2 ||
				k == vpm_pkg::KIND_TRAP_EL3) ? vpm_pkg::TRAP_CLASS : 6'h0;
			next_r.nv_addr = vpm_pkg::NV_BASE + {6'h0, req_op2, 3'h0};
			if (k == vpm_pkg::KIND_OK) begin
				if (req_write) begin
					// all 16 bits of each entry kept as written
					next_r.map[req_op2] = req_wdata;
				end else begin
					next_r.rdata = r.map[req_op2];
				end
			end
		end
		// miss gives partition zero rather than an unchecked entry
		if (map_apply) begin
			next_r.miss_i = !entry_ok(src_partition_i);
			next_r.miss_d = !entry_ok(src_partition_d);
			next_r.lab_i = entry_ok(src_partition_i) ?
				lookup(r.map, src_partition_i) : 16'h0;
			next_r.lab_d = entry_ok(src_partition_d) ?
				lookup(r.map, src_partition_d) : 16'h0;
		end else begin
			next_r.miss_i = 1'b0;
			next_r.miss_d = 1'b0;
			next_r.lab_i = src_partition_i;
			next_r.lab_d = src_partition_d;
		end
	end

	// entries need no reset value; zero keeps simulation clean
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			r.map <= {NUM_REGS{vpm_pkg::MAP_RESET}};
			r.resp_valid <= 1'b0;
			r.kind <= vpm_pkg::KIND_OK;
			r.cls <= 6'h0;
			r.nv_addr <= 12'h0;
			r.rdata <= 64'h0;
			r.lab_i <= 16'h0;
			r.lab_d <= 16'h0;
			r.miss_i <= 1'b0;
			r.miss_d <= 1'b0;
		end else begin
			r <= next_r;
		end
	end

	assign resp_valid = r.resp_valid;
	assign resp_kind = r.kind;
	assign resp_class = r.cls;
	assign resp_nv_addr = r.nv_addr;
	assign resp_rdata = r.rdata;
	assign label_partition_i = r.lab_i;
	assign label_partition_d = r.lab_d;
	assign label_miss_i = r.miss_i;
	assign label_miss_d = r.miss_d;

	// ************************************
	// checks
	// ************************************
	property p_el0_undef;
		@(posedge clk) disable iff (!rstn)
		sel && cur_el == vpm_pkg::EL0 |=>
			resp_valid && resp_kind == vpm_pkg::KIND_UNDEF;
	endproperty
	a_el0_undef: assert property (p_el0_undef)
		else $error("el0 access not undefined");

	property p_absent;
		@(posedge clk) disable iff (!rstn)
		sel && 32'(req_op2) >= NUM_REGS |=>
			resp_kind == vpm_pkg::KIND_UNDEF;
	endproperty
	a_absent: assert property (p_absent)
		else $error("absent register not undefined");

	property p_nested_save_area;
		@(posedge clk) disable iff (!rstn)
		sel && present && cur_el == vpm_pkg::EL1 && el2_enabled &&
			nested_virt_bit && nested_virt_memory_bit &&
			req_op2 == vpm_pkg::REG_IDX_1 |=>
			resp_kind == vpm_pkg::KIND_NESTED_SAVE_AREA && resp_nv_addr == 12'h948;
	endproperty
	a_nested_save_area: assert property (p_nested_save_area)
		else $error("nested redirect address wrong");

	property p_trap_el2;
		@(posedge clk) disable iff (!rstn)
		sel && present && cur_el == vpm_pkg::EL1 && el2_enabled &&
			nested_virt_bit && !nested_virt_memory_bit &&
			!(el3_present && trap_lower_levels) |=>
			resp_kind == vpm_pkg::KIND_TRAP_EL2 && resp_class == 6'h18;
	endproperty
	a_trap_el2: assert property (p_trap_el2)
		else $error("el1 access did not trap to el2");

	property p_trap_el3;
		@(posedge clk) disable iff (!rstn)
		sel && present && cur_el == vpm_pkg::EL2 && el3_present &&
			trap_lower_levels && !(halted && secure_debug_disable) |=>
			resp_kind == vpm_pkg::KIND_TRAP_EL3 && resp_class == 6'h18;
	endproperty
	a_trap_el3: assert property (p_trap_el3)
		else $error("el2 access did not trap to el3");

	property p_halt_undef;
		@(posedge clk) disable iff (!rstn)
		sel && present && cur_el == vpm_pkg::EL2 && el3_present &&
			trap_lower_levels && halted && secure_debug_disable |=>
			resp_kind == vpm_pkg::KIND_UNDEF && resp_class == 6'h0;
	endproperty
	a_halt_undef: assert property (p_halt_undef)
		else $error("halted secure access not undefined");

	property p_write_read;
		@(posedge clk) disable iff (!rstn)
		sel && present && cur_el == vpm_pkg::EL3 && req_write &&
			req_op2 == vpm_pkg::REG_IDX_0 ##1
			sel && present && cur_el == vpm_pkg::EL3 && !req_write &&
			req_op2 == vpm_pkg::REG_IDX_0 |=>
			resp_rdata == $past(req_wdata, 2);
	endproperty
	a_write_read: assert property (p_write_read)
		else $error("el3 read did not return written value");

	property p_pass;
		@(posedge clk) disable iff (!rstn)
		!map_apply |=> label_partition_i == $past(src_partition_i) &&
			!label_miss_i;
	endproperty
	a_pass: assert property (p_pass)
		else $error("unmapped id was altered");

	property p_miss;
		@(posedge clk) disable iff (!rstn)
		map_apply && src_partition_d < NUM_IDS &&
			!map_entry_valid[src_partition_d[4:0]] |=>
			label_miss_d && label_partition_d == 16'h0;
	endproperty
	a_miss: assert property (p_miss)
		else $error("invalid entry used for labelling");

	property p_no_el2;
		@(posedge clk) disable iff (!rstn)
		!el2_enabled |=> !label_miss_i && !label_miss_d;
	endproperty
	a_no_el2: assert property (p_no_el2)
		else $error("mapping active without el2");

endmodule : vpm_regs

`default_nettype wire

// ==== inc/vpm_pkg.sv ====
/*
 * constants and types for the virtual partition map register bank.
 * assumes the system-register path of the processing element presents
 * decoded encoding fields and the current exception level each cycle.
 */
// Summary of operation
// - four 16-bit physical entries per 64-bit register
// - register n maps virtual ids 4n to 4n+3
// - warm reset leaves entries unknown; zero chosen
// - report highest implemented map register index
// - max index zero means only register zero
// - el1/el0 ids mapped only when enabled
// - entry valid only while its valid bit set
// - absent register access is undefined
// - no labelling effect without el2 enabled
// - selected by fixed encoding, op2 is index
// - el0 access is undefined
// - el1 nested memory mode redirects to save area
// - el1 nested mode traps to el2, else undefined
// - trap-lower traps to el3 unless halted secure
// - el2 untrapped and el3 read/write the register
// - mapped virtual ids label memory requests
`default_nettype none

package vpm_pkg;

	// ************************************
	// encoding and layout
	// ************************************
	localparam logic [1:0] ENC_OP0 = 2'h3;
	localparam logic [2:0] ENC_OP1 = 3'h4;
	localparam logic [3:0] ENC_CRN = 4'hA;
	localparam logic [3:0] ENC_CRM = 4'h6;
	localparam logic [2:0] REG_IDX_0 = 3'h0;
	localparam logic [2:0] REG_IDX_1 = 3'h1;
	localparam logic [2:0] REG_IDX_2 = 3'h2;
	localparam int ENTRY_W = 16;
	localparam int ENTRIES_PER_REG = 4;
	localparam int MAX_REGS = 8;
	localparam int DEF_NUM_REGS = 3;
	localparam logic [63:0] MAP_RESET = 64'h0;
	localparam logic [11:0] NV_BASE = 12'h940;
	localparam logic [5:0] TRAP_CLASS = 6'h18;

	// ************************************
	// exception levels and outcomes
	// ************************************
	localparam logic [1:0] EL0 = 2'h0;
	localparam logic [1:0] EL1 = 2'h1;
	localparam logic [1:0] EL2 = 2'h2;
	localparam logic [1:0] EL3 = 2'h3;

	typedef enum logic [2:0] {
		KIND_OK = 3'b000,
		KIND_UNDEF = 3'b001,
		KIND_TRAP_EL2 = 3'b010,
		KIND_TRAP_EL3 = 3'b011,
		KIND_NESTED_SAVE_AREA = 3'b100
	} vpm_kind_e;

endpackage : vpm_pkg

`default_nettype wire

// ==== tb/vpm_regs_bench.sv ====
/*
 * self-checking bench for the virtual partition map register bank.
 * assumes the bank is built with three map registers and answers one cycle late.
 */
`timescale 1ns/10ps
`default_nettype none

module vpm_regs_bench;

	// ************************************
	// stimulus and expectation state
	// ************************************
	localparam int NR = 3;
	logic clk = 1'b0, rstn = 1'b0, req_valid = 1'b0, req_write = 1'b0;
	logic [1:0] req_op0 = vpm_pkg::ENC_OP0;
	logic [2:0] req_op1 = vpm_pkg::ENC_OP1;
	logic [3:0] req_crn = vpm_pkg::ENC_CRN;
	logic [3:0] req_crm = vpm_pkg::ENC_CRM;
	logic [2:0] req_op2 = 3'h0;
	logic [63:0] req_wdata = 64'h0;
	logic [1:0] cur_el = 2'h3;
	logic el2_enabled = 0, nested_virt_bit = 0, nested_virt_memory_bit = 0, el3_present = 0;
	logic trap_lower_levels = 0, halted = 0, secure_debug_disable = 0;
	logic virtualization_present = 1, el0_map_enable = 0, el1_map_enable = 0, src_is_el1 = 0;
	logic [31:0] map_entry_valid = 32'h0;
	logic [15:0] src_partition_i = 16'h0, src_partition_d = 16'h0;
	logic resp_valid, label_miss_i, label_miss_d;
	vpm_pkg::vpm_kind_e resp_kind;
	logic [5:0] resp_class;
	logic [11:0] resp_nv_addr;
	logic [63:0] resp_rdata;
	logic [2:0] map_register_max_index;
	logic [15:0] label_partition_i, label_partition_d;
	logic [63:0] mir [0:NR-1];
	logic [63:0] lastrd = 64'h0;
	int err_total = 0, checks_done = 0, i;
	integer seed = 64702;
	logic [31:0] r;

	vpm_regs #(.NUM_REGS(NR)) vpm_regs_i (.clk, .rstn, .req_valid, .req_write, .req_op0,
		.req_op1, .req_crn, .req_crm, .req_op2, .req_wdata, .cur_el, .el2_enabled,
		.nested_virt_bit, .nested_virt_memory_bit, .el3_present, .trap_lower_levels, .halted,
		.secure_debug_disable, .virtualization_present, .resp_valid, .resp_kind, .resp_class,
		.resp_nv_addr, .resp_rdata, .map_register_max_index, .el0_map_enable, .el1_map_enable,
		.map_entry_valid, .src_is_el1, .src_partition_i, .src_partition_d, .label_partition_i,
		.label_partition_d, .label_miss_i, .label_miss_d);

	always #4 clk = ~clk;

	// ************************************
	// reference functions
	// ************************************
	function automatic vpm_pkg::vpm_kind_e ek(input logic [2:0] o2);
		logic tl;
		vpm_pkg::vpm_kind_e up;
		tl = el3_present & trap_lower_levels;
		up = (halted & secure_debug_disable) ? vpm_pkg::KIND_UNDEF : vpm_pkg::KIND_TRAP_EL3;
		if (o2 >= NR || !virtualization_present) return vpm_pkg::KIND_UNDEF;
		if (cur_el == 2'h0) return vpm_pkg::KIND_UNDEF;
		if (cur_el == 2'h1) begin
			if (el2_enabled & nested_virt_bit & nested_virt_memory_bit) return vpm_pkg::KIND_NESTED_SAVE_AREA;
			if (el2_enabled & nested_virt_bit) return tl ? up : vpm_pkg::KIND_TRAP_EL2;
			return vpm_pkg::KIND_UNDEF;
		end
		if (cur_el == 2'h2 && tl) return up;
		return vpm_pkg::KIND_OK;
	endfunction : ek

	// returns miss flag over label
	function automatic logic [16:0] elab(input logic [15:0] s);
		if (!(virtualization_present & el2_enabled & (src_is_el1 ? el1_map_enable
			: el0_map_enable))) return {1'b0, s};
		if (s < 4 * NR && map_entry_valid[s[4:0]]) return {1'b0, mir[s / 4][16 * (s % 4) +: 16]};
		return {1'b1, 16'h0};
	endfunction : elab

	// ************************************
	// checking tasks
	// ************************************
	task automatic cmp(input logic [63:0] got, input logic [63:0] exp, input string what);
		checks_done++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : cmp

	// one cycle: request and label sources in, answers checked after the edge
	task automatic step(input logic v, input logic w, input logic good, input logic [2:0] o2,
		input logic [63:0] d);
		vpm_pkg::vpm_kind_e k;
		logic [16:0] li;
		logic [16:0] ld;
		req_valid = v;
		req_write = w;
		req_crm = good ? vpm_pkg::ENC_CRM : 4'h5;
		req_op2 = o2;
		req_wdata = d;
		k = ek(o2);
		li = elab(src_partition_i);
		ld = elab(src_partition_d);
		@(posedge clk);
		#1;
		cmp(resp_valid, v & good, "answer strobe");
		cmp(map_register_max_index, virtualization_present ? 3'h2 : 3'h0, "max index");
		cmp({label_miss_i, label_partition_i}, li, "label i");
		cmp({label_miss_d, label_partition_d}, ld, "label d");
		if (v & good) begin
			cmp(resp_kind, k, "outcome");
			cmp(resp_class, (k == vpm_pkg::KIND_TRAP_EL2 || k == vpm_pkg::KIND_TRAP_EL3)
				? 6'h18 : 6'h0, "class");
			cmp(resp_nv_addr, 12'h940 + {6'h0, o2, 3'h0}, "save address");
			if (k == vpm_pkg::KIND_OK) begin
				if (w) mir[o2] = d;
				else lastrd = mir[o2];
			end
			cmp(resp_rdata, lastrd, "read data");
		end
	endtask : step

	task print_verdict;
		$display("checks %0d errors %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : print_verdict

	// ************************************
	// sequence
	// ************************************
	initial begin
		#(8 * 3000);
		err_total++;
		print_verdict();
	end

	initial begin
		repeat (20) @(posedge clk);
		#1;
		rstn = 1'b1;
		for (i = 0; i < NR; i++) step(1, 1, 1, i[2:0], {$random(seed), $random(seed)});
		for (i = NR - 1; i >= 0; i--) step(1, 0, 1, i[2:0], 64'h0);
		step(1, 0, 0, 3'h0, 64'h0);
		step(1, 1, 1, 3'h3, 64'hFFFF);
		cur_el = 2'h0;
		step(1, 1, 1, 3'h0, 64'h1234);
		cur_el = 2'h3;
		virtualization_present = 1'b0;
		step(1, 0, 1, 3'h0, 64'h0);
		virtualization_present = 1'b1;
		// nested, trap and halted corners are seldom drawn at random
		cur_el = 2'h1;
		{el2_enabled, nested_virt_bit, nested_virt_memory_bit} = 3'h7;
		step(1, 1, 1, 3'h1, 64'h5A5A);
		nested_virt_memory_bit = 1'b0;
		step(1, 0, 1, 3'h0, 64'h0);
		{el3_present, trap_lower_levels} = 2'h3;
		step(1, 0, 1, 3'h2, 64'h0);
		cur_el = 2'h2;
		step(1, 1, 1, 3'h1, 64'h7777);
		{halted, secure_debug_disable} = 2'h3;
		step(1, 0, 1, 3'h0, 64'h0);
		{nested_virt_bit, el3_present, trap_lower_levels, halted, secure_debug_disable} = 5'h0;
		step(1, 1, 1, 3'h1, {$random(seed), $random(seed)});
		step(1, 0, 1, 3'h1, 64'h0);
		cur_el = 2'h1;
		step(1, 0, 1, 3'h1, 64'h0);
		cur_el = 2'h3;
		step(1, 1, 1, 3'h0, {$random(seed), $random(seed)});
		step(1, 0, 1, 3'h0, 64'h0);
		el2_enabled = 1'b1;
		el0_map_enable = 1'b1;
		map_entry_valid = 32'hFFFFFFFF;
		src_partition_i = 16'h000B;
		src_partition_d = 16'h000C;
		step(0, 0, 1, 3'h0, 64'h0);
		el2_enabled = 1'b0;
		step(0, 0, 1, 3'h0, 64'h0);
		for (i = 0; i < 400; i++) begin
			r = $random(seed);
			cur_el = r[1:0];
			{el2_enabled, nested_virt_bit, nested_virt_memory_bit, el3_present} = r[5:2];
			{trap_lower_levels, halted, secure_debug_disable} = r[8:6];
			virtualization_present = r[11:9] != 3'h0;
			{el0_map_enable, el1_map_enable, src_is_el1} = r[14:12];
			src_partition_i = {12'h0, r[18:15]};
			src_partition_d = r[19] ? 16'h0003 : {12'h0, r[23:20]};
			map_entry_valid = $random(seed);
			step(r[24], r[25], r[27:26] != 2'h0, {r[28] & r[29], r[31:30]},
				{$random(seed), $random(seed)});
		end
		print_verdict();
	end

endmodule : vpm_regs_bench

`default_nettype wire
